// ---- include/adcso_params.svh ----
// Timing counts, field positions and reset values of the serial output block.
// Assumes a 40 MHz system clock; the status test count and the on-chip divider below are derived from that rate.
`ifndef ADCSO_PARAMS_SVH
`define ADCSO_PARAMS_SVH

// System clock rate in kHz (period 25 ns).
`define ADCSO_CLK_KHZ 40000
// Status test delay in ns and its least count of clock cycles, rounded up.
`define ADCSO_EOC_TEST_NS 500
`define ADCSO_EOC_TEST_CYC ((`ADCSO_EOC_TEST_NS * `ADCSO_CLK_KHZ + 999999) / 1000000)
// On-chip oscillator sample rate in kHz and the divider that yields it.
`define ADCSO_INT_OSC_KHZ 1800
`define ADCSO_INT_OSC_DIV (`ADCSO_CLK_KHZ / `ADCSO_INT_OSC_KHZ)
// External oscillator edges per modulator sample.
`define ADCSO_EXT_OSC_DIV 3'h5
// Half period of the generated serial clock, in system clock cycles.
`define ADCSO_SCK_HALF_CYC 20
// Frame length in serial clock edges.
`define ADCSO_FRAME_BITS 6'h20
// Rising edges needed before an abort takes a full code as the programmed ratio.
`define ADCSO_ABORT_MIN_EDGES 6'h05
// Ratio code width and its full-width shift for partial codes.
`define ADCSO_CODE_BITS 3'h5
// Conversion length is 2^RATE_SHIFT times the ratio: output rate is null / 8.
`define ADCSO_RATE_SHIFT 5'h03
// Ratio code decoding: exponent of two for each valid code.
`define ADCSO_CODE_TIE_LOW 5'h00
`define ADCSO_CODE_TIE_HIGH 4'hF
`define ADCSO_CODE_LOW_MIN 4'h1
`define ADCSO_CODE_LOW_MAX 4'h9
`define ADCSO_CODE_EXP_OFFSET 4'h5
`define ADCSO_EXP_TIE_LOW 4'h8
`define ADCSO_EXP_MAX 4'hF
// Reset values.
`define ADCSO_CODE_RESET 5'h00
`define ADCSO_EXP_RESET 4'h8

`endif

// ---- include/adcso_pkg.sv ----
// Types of the converter serial output block: states and state records.
// Assumes nothing beyond a SystemVerilog compiler.
package adcso_pkg;

  // Sequencer states, one-hot.
  typedef enum logic [3:0] {
    ADCSO_CONV  = 4'h1,
    ADCSO_SLEEP = 4'h2,
    ADCSO_TEST  = 4'h4,
    ADCSO_SHIFT = 4'h8
  } adcso_state_t;

  // Whole state of the serial output core.
  typedef struct packed {
    adcso_state_t st;
    logic         cs_m;
    logic         cs_s;
    logic         cs_d;
    logic         sck_m;
    logic         sck_s;
    logic         sck_d;
    logic         sdi_m;
    logic         sdi_s;
    logic         sel_m;
    logic         sel_s;
    logic         cont_m;
    logic         cont_s;
    logic [31:0]  shreg;
    logic [5:0]   cnt;
    logic [7:0]   tmr;
    logic [4:0]   code;
    logic [4:0]   inshift;
    logic [3:0]   exp;
    logic [18:0]  conv_cnt;
    logic         sdo;
    logic         sdo_oe;
    logic         sck;
    logic         sck_oe;
    logic         busy;
  } adcso_core_t;

  // Whole state of the modulator rate generator.
  typedef struct packed {
    logic        osc_m;
    logic        osc_s;
    logic        osc_d;
    logic        drv_m;
    logic        drv_s;
    logic [2:0]  ecnt;
    logic [15:0] icnt;
    logic        en;
  } adcso_rate_t;

endpackage

// ---- logic/adcso_rate.sv ----
// Modulator sample-rate enable generator.
// Assumes the oscillator pin and its select strap are asynchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "adcso_params.svh"

module adcso_rate #(
  parameter logic [15:0] INT_DIV = 16'(`ADCSO_INT_OSC_DIV)
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic osc_pin_i,
  input  wire logic osc_driven_i,
  output logic      sample_en_o
);

  adcso_pkg::adcso_rate_t r;
  adcso_pkg::adcso_rate_t next_r;

  // --------------------------------------------------------------------------
  // Sample enable
  // --------------------------------------------------------------------------

  // One pulse per modulator sample, from the on-chip divider or from every
  // fifth external edge; the external clock must stay below half of clk_i.
  always_comb
  begin
    next_r       = r;
    next_r.osc_m = osc_pin_i;
    next_r.osc_s = r.osc_m;
    next_r.osc_d = r.osc_s;
    next_r.drv_m = osc_driven_i;
    next_r.drv_s = r.drv_m;
    next_r.en    = 1'b0;
    if (r.drv_s)
    begin
      next_r.icnt = 16'h0000;
      if (r.osc_s && !r.osc_d)
      begin
        if (r.ecnt == `ADCSO_EXT_OSC_DIV - 3'h1)
        begin
          next_r.ecnt = 3'h0;
          next_r.en   = 1'b1; // [R19]
        end
        else
        begin
          next_r.ecnt = r.ecnt + 3'h1;
        end
      end
    end
    else
    begin
      next_r.ecnt = 3'h0;
      if (r.icnt >= INT_DIV - 16'h0001)
      begin
        next_r.icnt = 16'h0000;
        next_r.en   = 1'b1; // [R18]
      end
      else
      begin
        next_r.icnt = r.icnt + 16'h0001;
      end
    end
  end

  // State register.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign sample_en_o = r.en;

endmodule // adcso_rate

`default_nettype wire

// ---- logic/adcso_core.sv ----
// Serial result output of a delta-sigma converter: conversion timing, sleep,
// status test, 32-bit frame shifting on an external or generated serial clock.
// Assumes all pins are asynchronous and the result word is valid at all times.
`timescale 1ns/1ps
`default_nettype none
`include "adcso_params.svh"

// Operation
// R1: Conversion end loads result into shift register.
// R2: External clock: sleep until first rising edge.
// R3: External clock: 32nd falling edge restarts conversion.
// R4: System ties select high for generated clock.
// R5: Output floats while chip select high.
// R6: Busy high converting, low until read.
// R7: Generated clock starts after status test delay.
// R8: Early chip select rise keeps device asleep.
// R9: Generated clock drives frame on clock pin.
// R10: After 32nd rise: output high, clock high.
// R11: Chip select rise mid-frame aborts, converts.
// R12: Short aborts use partial ratio code once.
// R13: Continuous mode: all high converting, low sleeping.
// R14: Continuous mode starts frame after sleep delay.
// R15: Continuous mode: clock high throughout conversion.
// R16: First bit is inverted done flag.
// R17: Conversion spans eight times ratio samples.
// R18: Grounded oscillator pin uses on-chip rate.
// R19: External oscillator divided by five.
// R20: System ties select low for host clock.
// R21: Ratio code shifted in applies next conversion.
// R22: Frame is 32 edges, counted from first.
module adcso_core #(
  parameter logic [15:0] SAMPLE_DIV = 16'(`ADCSO_INT_OSC_DIV)
) (
  input  wire logic        CLOCK_I,
  input  wire logic        RST_I,
  input  wire logic        CS_N_I,
  input  wire logic        SCK_I,
  input  wire logic        SDI_I,
  input  wire logic        CLOCK_SOURCE_SELECT_I,
  input  wire logic        CONTINUOUS_MODE_I,
  input  wire logic        OSCILLATOR_INPUT_I,
  input  wire logic        OSC_DRIVEN_I,
  input  wire logic [30:0] RESULT_I,
  output logic             SDO_O,
  output logic             SDO_OE_O,
  output logic             SCK_O,
  output logic             SCK_OE_O,
  output logic             BUSY_O,
  output logic [4:0]       OSR_CODE_O
);

  localparam logic [7:0] TEST_LAST = 8'(`ADCSO_EOC_TEST_CYC - 1);
  localparam logic [7:0] HALF_LAST = 8'(`ADCSO_SCK_HALF_CYC - 1);

  adcso_pkg::adcso_core_t r;
  adcso_pkg::adcso_core_t next_r;
  logic                   sample_en;
  logic                   sck_rise;
  logic                   sck_fall;
  logic                   cs_fall;
  logic                   internal;
  logic                   cont;
  logic [18:0]            conv_last;

  // Returns {valid, exponent of two} for a ratio selection code.
  function automatic logic [4:0] osr_decode(input logic [4:0] c);
    logic [4:0] res;
    res = 5'h00;
    if (c == `ADCSO_CODE_TIE_LOW)
      res = {1'b1, `ADCSO_EXP_TIE_LOW};
    else if (c[3:0] == `ADCSO_CODE_TIE_HIGH)
      res = {1'b1, `ADCSO_EXP_MAX};
    else if (c[3:0] >= `ADCSO_CODE_LOW_MIN && c[3:0] <= `ADCSO_CODE_LOW_MAX)
      res = {1'b1, c[3:0] + `ADCSO_CODE_EXP_OFFSET};
    return res;
  endfunction

  // --------------------------------------------------------------------------
  // Modulator rate
  // --------------------------------------------------------------------------

  adcso_rate #(
    .INT_DIV (SAMPLE_DIV)
  ) u_rate (
    .clk_i        (CLOCK_I),
    .rst_i        (RST_I),
    .osc_pin_i    (OSCILLATOR_INPUT_I),
    .osc_driven_i (OSC_DRIVEN_I),
    .sample_en_o  (sample_en)
  );

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------

  // Edge and mode terms, taken from second synchroniser stages and, for edges, their delayed copies.
  assign sck_rise  = r.sck_s & ~r.sck_d;
  assign sck_fall  = ~r.sck_s & r.sck_d;
  assign cs_fall   = ~r.cs_s & r.cs_d;
  assign internal  = r.sel_s;
  assign cont      = r.cont_s & r.sel_s;
  assign conv_last = (19'h00001 << (5'(r.exp) + `ADCSO_RATE_SHIFT)) - 19'h00001; // [R17]

  // Next-state logic. The serial input is captured only for the first five
  // rising edges; later input bits are ignored since the code is five bits.
  always_comb
  begin
    logic       capture;
    logic       start_conv;
    logic [4:0] partial;
    logic [4:0] dec;
    capture    = 1'b0;
    start_conv = 1'b0;
    partial    = 5'h00;
    dec        = 5'h00;
    next_r        = r;
    next_r.cs_m   = CS_N_I;
    next_r.cs_s   = r.cs_m;
    next_r.cs_d   = r.cs_s;
    next_r.sck_m  = SCK_I;
    next_r.sck_s  = r.sck_m;
    next_r.sck_d  = r.sck_s;
    next_r.sdi_m  = SDI_I;
    next_r.sdi_s  = r.sdi_m;
    next_r.sel_m  = CLOCK_SOURCE_SELECT_I;
    next_r.sel_s  = r.sel_m;
    next_r.cont_m = CONTINUOUS_MODE_I;
    next_r.cont_s = r.cont_m;
    case (r.st)
      adcso_pkg::ADCSO_CONV:
      begin
        if (internal && !cont && cs_fall)
          next_r.sck = 1'b0; // [R5]
        else if (cont)
          next_r.sck = 1'b1; // [R15]
        if (sample_en)
        begin
          if (r.conv_cnt == conv_last)
          begin
            next_r.conv_cnt = 19'h00000;
            next_r.shreg    = {1'b0, RESULT_I}; // [R1] [R16]
            next_r.st       = adcso_pkg::ADCSO_SLEEP;
            if (internal)
              next_r.sck = 1'b0; // [R13]
          end
          else
          begin
            next_r.conv_cnt = r.conv_cnt + 19'h00001;
          end
        end
      end
      adcso_pkg::ADCSO_SLEEP:
      begin
        next_r.cnt     = 6'h00;
        next_r.tmr     = 8'h00;
        next_r.inshift = 5'h00;
        if (internal)
          next_r.sck = 1'b0;
        if (!internal)
        begin
          if (!r.cs_s && sck_rise)
          begin
            next_r.st  = adcso_pkg::ADCSO_SHIFT; // [R2]
            next_r.cnt = 6'h01;
            capture    = 1'b1;
          end
        end
        else if (cont || !r.cs_s)
        begin
          next_r.st = adcso_pkg::ADCSO_TEST; // [R7] [R14]
        end
      end
      adcso_pkg::ADCSO_TEST:
      begin
        if (!internal || (!cont && r.cs_s))
        begin
          next_r.st = adcso_pkg::ADCSO_SLEEP; // [R8]
        end
        else if (r.tmr >= TEST_LAST)
        begin
          next_r.st  = adcso_pkg::ADCSO_SHIFT; // [R7] [R9]
          next_r.sck = 1'b1;
          next_r.tmr = 8'h00;
          next_r.cnt = 6'h01; // [R22]
          capture    = 1'b1;
        end
        else
        begin
          next_r.tmr = r.tmr + 8'h01;
        end
      end
      adcso_pkg::ADCSO_SHIFT:
      begin
        if (!cont && r.cs_s)
        begin
          start_conv = 1'b1; // [R11]
        end
        else if (internal)
        begin
          if (r.tmr >= HALF_LAST)
          begin
            next_r.tmr = 8'h00;
            if (r.sck)
            begin
              if (r.cnt == `ADCSO_FRAME_BITS)
                start_conv = 1'b1; // [R10] [R15]
              else
              begin
                next_r.sck   = 1'b0; // [R9]
                next_r.shreg = {r.shreg[30:0], 1'b1};
              end
            end
            else
            begin
              next_r.sck = 1'b1;
              next_r.cnt = r.cnt + 6'h01; // [R22]
              capture    = 1'b1;
            end
          end
          else
          begin
            next_r.tmr = r.tmr + 8'h01;
          end
        end
        else if (sck_rise)
        begin
          next_r.cnt = r.cnt + 6'h01; // [R22]
          capture    = 1'b1;
        end
        else if (sck_fall)
        begin
          if (r.cnt == `ADCSO_FRAME_BITS)
            start_conv = 1'b1; // [R3]
          else
            next_r.shreg = {r.shreg[30:0], 1'b1}; // [R2]
        end
      end
      default:
      begin
        next_r.st = adcso_pkg::ADCSO_CONV;
      end
    endcase
    // Ratio code bits arrive most significant first on rising edges.
    if (capture && r.cnt < `ADCSO_ABORT_MIN_EDGES)
      next_r.inshift = {r.inshift[3:0], r.sdi_s}; // [R21]
    // A full code that decodes becomes the programmed ratio; a short one that decodes is used once.
    if (start_conv)
    begin
      next_r.st       = adcso_pkg::ADCSO_CONV;
      next_r.conv_cnt = 19'h00000;
      next_r.cnt      = 6'h00;
      next_r.tmr      = 8'h00;
      if (internal)
        next_r.sck = 1'b1; // [R10]
      if (r.cnt >= `ADCSO_ABORT_MIN_EDGES)
      begin
        dec = osr_decode(r.inshift);
        if (dec[4])
          next_r.code = r.inshift; // [R21]
        else
          dec = osr_decode(r.code);
      end
      else
      begin
        partial = r.inshift << (`ADCSO_CODE_BITS - r.cnt[2:0]);
        dec     = osr_decode(partial); // [R12]
        if (!dec[4])
          dec = osr_decode(r.code);
      end
      if (dec[4])
        next_r.exp = dec[3:0];
    end
    // Pin drivers, registered together with the state.
    next_r.busy   = (next_r.st == adcso_pkg::ADCSO_CONV); // [R6] [R13]
    next_r.sdo    = (next_r.st == adcso_pkg::ADCSO_CONV) | next_r.shreg[31]; // [R16]
    next_r.sdo_oe = ~next_r.cs_s; // [R5]
    next_r.sck_oe = next_r.sel_s; // [R9]
  end

  // State register.
  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      r       <= '0;
      r.st    <= adcso_pkg::ADCSO_CONV;
      r.cs_m  <= 1'b1;
      r.cs_s  <= 1'b1;
      r.cs_d  <= 1'b1;
      r.code  <= `ADCSO_CODE_RESET;
      r.exp   <= `ADCSO_EXP_RESET;
      r.sdo   <= 1'b1;
      r.busy  <= 1'b1;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign SDO_O      = r.sdo;
  assign SDO_OE_O   = r.sdo_oe;
  assign SCK_O      = r.sck;
  assign SCK_OE_O   = r.sck_oe;
  assign BUSY_O     = r.busy;
  assign OSR_CODE_O = r.code;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------

  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (RST_I);

  sequence ext_last_fall;
    !r.sel_s && r.st == adcso_pkg::ADCSO_SHIFT && !r.cs_s && sck_fall &&
      r.cnt == `ADCSO_FRAME_BITS;
  endsequence

  sequence int_last_half;
    r.sel_s && r.st == adcso_pkg::ADCSO_SHIFT && !(r.cs_s && !cont) && r.sck &&
      r.cnt == `ADCSO_FRAME_BITS && r.tmr >= HALF_LAST;
  endsequence

  load_result_a: assert property ( // [R1]
    r.st == adcso_pkg::ADCSO_CONV && next_r.st == adcso_pkg::ADCSO_SLEEP
      |=> r.shreg == {1'b0, $past(RESULT_I)} && !BUSY_O && !SDO_O)
    else $error("Result not loaded at conversion end.");

  ext_wake_a: assert property ( // [R2]
    !r.sel_s && r.st == adcso_pkg::ADCSO_SLEEP && !sck_rise |=> r.st != adcso_pkg::ADCSO_SHIFT)
    else $error("Left sleep without a serial clock rise.");

  ext_end_a: assert property ( // [R3]
    ext_last_fall |=> r.st == adcso_pkg::ADCSO_CONV && SDO_O && BUSY_O)
    else $error("No restart on the last falling edge.");

  sdo_float_a: assert property ( // [R5]
    r.cs_s |-> !SDO_OE_O)
    else $error("Serial output driven while deselected.");

  busy_read_a: assert property ( // [R6]
    r.st != adcso_pkg::ADCSO_CONV |-> !BUSY_O ##1 (r.st == adcso_pkg::ADCSO_CONV || !BUSY_O))
    else $error("Busy high before the frame was read.");

  test_wait_a: assert property ( // [R7]
    r.st == adcso_pkg::ADCSO_TEST && r.tmr < TEST_LAST |=> r.st != adcso_pkg::ADCSO_SHIFT)
    else $error("Frame started before the status test delay.");

  keep_sleep_a: assert property ( // [R8]
    r.st == adcso_pkg::ADCSO_TEST && r.cs_s && !cont
      |=> r.st == adcso_pkg::ADCSO_SLEEP && $stable(r.shreg))
    else $error("Early deselect did not keep sleep.");

  frame_end_a: assert property ( // [R10]
    int_last_half |=> r.st == adcso_pkg::ADCSO_CONV && SCK_O && SDO_O ##1 SCK_O)
    else $error("Frame end did not hold clock and output high.");

  abort_now_a: assert property ( // [R11]
    r.st == adcso_pkg::ADCSO_SHIFT && r.cs_s && !cont |=> r.st == adcso_pkg::ADCSO_CONV)
    else $error("Abort did not start a conversion.");

  cont_sleep_a: assert property ( // [R13]
    cont && (r.st == adcso_pkg::ADCSO_SLEEP || r.st == adcso_pkg::ADCSO_TEST)
      |-> !SCK_O && !SDO_O && !BUSY_O)
    else $error("Continuous sleep lines not all low.");

endmodule // adcso_core

`default_nettype wire

// ---- tb/adcso_host_model.sv ----
// Serial master model standing at the far side of the converter's result pins.
// Assumes one system clock; the pin level on the serial clock wire is resolved
// by the testbench and fed back on dev_sck_i.
`timescale 1ns/1ps
`default_nettype none

module adcso_host_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ext_i,
  input  wire logic        start_i,
  input  wire logic        dev_sck_i,
  input  wire logic        sdo_i,
  input  wire logic        busy_i,
  input  wire logic [4:0]  code_i,
  output logic             sck_o,
  output logic             sdi_o,
  output logic             done_o,
  output logic [31:0]      frame_o,
  output logic [5:0]       rises_o
);
  logic       sck_q;
  logic [3:0] div;
  logic       run;
  logic       sck;

  // The host's own clock only counts when it, not the device, owns the wire.
  assign sck = ext_i ? sck_o : dev_sck_i;

  // ---------------------------------------------------------------------
  // Frame engine: slow host clock, rising-edge capture, ratio code output.
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      {sck_o, sck_q, run, div, rises_o, frame_o, done_o, sdi_o} <= '0;
    end
    else
    begin
      done_o <= 1'b0;
      sck_q  <= sck;
      if (start_i)
        run <= 1'b1;
      // Sixteen clocks a half period leaves room for the device's pin syncing.
      if (run)
      begin
        div <= div + 4'h1;
        if (div == 4'hF)
        begin
          sck_o <= ~sck_o;
          if (sck_o && rises_o == 6'h20)
            run <= 1'b0;                          // Stand still after the frame.
        end
      end
      if (busy_i && !run)
        rises_o <= 6'h00;
      if (sck && !sck_q)
      begin
        rises_o <= rises_o + 6'h01;
        frame_o <= {frame_o[30:0], sdo_i};
        if (rises_o == 6'h1F)
          done_o <= 1'b1;
      end
      // Code bits go out while the clock is low; past the fifth edge the line
      // toggles so that nothing beyond the code can pass for valid data.
      if (!sck)
        sdi_o <= (rises_o < 6'h05) ? code_i[3'h4 - rises_o[2:0]] : ~sdi_o;
    end
  end
endmodule // adcso_host_model

`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench of the converter's serial result output.
// Assumes the design core and the host model; the sample divider is set to 1.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic        clk = 1'b0, rst = 1'b1, cs_n = 1'b1, sel = 1'b1, cont = 1'b0;
  logic        osc = 1'b0, osc_drv = 1'b0, ph = 1'b0, start = 1'b0;
  logic [30:0] res = '0;
  logic [4:0]  code = 5'h01;
  logic        sdo, sck_o, sck_oe, sdo_oe, busy, h_sck, sdi, done;
  logic [4:0]  oversample_ratio;
  logic [31:0] frame;
  logic [5:0]  rises;
  logic        sck_w, sdo_w;
  logic [31:0] exp_q[$];
  int          miscompares = 0, samples_checked = 0, cycles = 0, n, seed;

  always #12.5 clk = ~clk;
  assign sck_w = sck_oe ? sck_o : h_sck;
  // An undriven data line shows the inverse, not a stale copy.
  assign sdo_w = sdo_oe ? sdo : ~sdo;

  adcso_core #(.SAMPLE_DIV(16'h0001)) i_adcso_core (
    .CLOCK_I(clk), .RST_I(rst), .CS_N_I(cs_n), .SCK_I(sck_w), .SDI_I(sdi),
    .CLOCK_SOURCE_SELECT_I(sel), .CONTINUOUS_MODE_I(cont), .OSCILLATOR_INPUT_I(osc),
    .OSC_DRIVEN_I(osc_drv), .RESULT_I(res), .SDO_O(sdo), .SDO_OE_O(sdo_oe),
    .SCK_O(sck_o), .SCK_OE_O(sck_oe), .BUSY_O(busy), .OSR_CODE_O(oversample_ratio));

  adcso_host_model i_adcso_host_model (
    .clk_i(clk), .rst_i(rst), .ext_i(~sel), .start_i(start), .dev_sck_i(sck_w),
    .sdo_i(sdo_w), .busy_i(busy), .code_i(code), .sck_o(h_sck), .sdi_o(sdi),
    .done_o(done), .frame_o(frame), .rises_o(rises));

  // External oscillator: one toggle every two clocks, grounded when unused.
  always @(posedge clk)
  begin
    ph  <= ~ph;
    osc <= osc_drv ? (ph ? ~osc : osc) : 1'b0;
  end

  // ---------------------------------------------------------------------
  // Checking and closing.
  // ---------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    samples_checked++;
    if (seen !== expv)
    begin
      miscompares++;
      $display("Error at %0t ns: seen %0h expected %0h", $time, seen, expv);
    end
  endtask

  task automatic results();
    $display("checked %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Frames are judged on the falling edge, after the host's flops settle.
  always @(negedge clk)
  begin
    if (done === 1'b1)
    begin
      if (exp_q.size() == 0)
        check(frame, 32'hDEAD_0000);
      else
        check(frame, exp_q.pop_front());
    end
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      miscompares++;
      results();
    end
  end

  // ---------------------------------------------------------------------
  // Bounded waits; n returns the cycles spent.
  // ---------------------------------------------------------------------
  task automatic wait_busy(input logic lvl);
    n = 0;
    while (busy !== lvl && n < 20000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    // A busy line that never settles is a hang, so close the run at once.
    if (n >= 20000)
    begin
      miscompares++;
      results();
    end
  endtask

  task automatic wait_sck();
    n = 0;
    while (sck_o !== 1'b1 && n < 200)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    // A generated clock that never rises is a hang as well.
    if (n >= 200)
    begin
      miscompares++;
      results();
    end
  endtask

  task automatic do_reset(input logic s, input logic c);
    @(posedge clk);
    rst  <= 1'b1;
    sel  <= s;
    cont <= c;
    repeat (20) @(posedge clk);
    #1;
    check({busy, sdo_oe, 3'h0, oversample_ratio}, 32'h200);
    @(posedge clk) rst <= 1'b0;
  endtask

  // ---------------------------------------------------------------------
  // Main sequence.
  // ---------------------------------------------------------------------
  initial
  begin
    seed = $urandom(76);
    res  = 31'($urandom());
    // Generated clock, chip select low through the conversion.
    do_reset(1'b1, 1'b0);
    @(posedge clk) cs_n <= 1'b0;
    repeat (10) @(posedge clk);
    #1;
    check({sdo_oe, sdo, sck_o}, 32'h6);
    wait_busy(1'b0);
    exp_q.push_back({1'b0, res});
    @(posedge clk) res <= 31'($urandom());
    wait_sck();
    check(32'(n >= 18 && n <= 24), 32'h1);
    wait_busy(1'b1);
    repeat (2) @(posedge clk);
    #1;
    check({sdo, sck_o, 3'h0, oversample_ratio}, 32'h301);
    wait_busy(1'b0);
    check(32'(n >= 506 && n <= 518), 32'h1);
    // Abort in mid-frame after ten rising edges.
    n = 0;
    while (rises != 6'h0A && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
    cs_n <= 1'b1;
    #1;
    wait_busy(1'b1);
    check(32'(n <= 6), 32'h1);
    wait_busy(1'b0);
    check(32'(n >= 506 && n <= 518), 32'h1);
    exp_q.push_back({1'b0, res});
    // A short status test keeps the device asleep and the result held.
    @(posedge clk) cs_n <= 1'b0;
    repeat (8) @(posedge clk);
    cs_n <= 1'b1;
    res  <= 31'($urandom());
    osc_drv <= 1'b1;
    repeat (60) @(posedge clk);
    #1;
    check({busy, sck_o, rises}, 32'h0);
    @(posedge clk) cs_n <= 1'b0;
    wait_busy(1'b1);
    wait_busy(1'b0);
    check(32'(n >= 10200 && n <= 10300), 32'h1);
    @(posedge clk) osc_drv <= 1'b0;
    cs_n <= 1'b1;
    // Host-supplied clock on a two-wire link.
    res  <= 31'($urandom());
    code <= 5'h1F;
    do_reset(1'b0, 1'b0);
    @(posedge clk) cs_n <= 1'b0;
    wait_busy(1'b0);
    exp_q.push_back({1'b0, res});
    repeat (30) @(posedge clk);
    #1;
    check({busy, rises}, 32'h0);
    @(posedge clk) start <= 1'b1;
    @(posedge clk) start <= 1'b0;
    wait_busy(1'b1);
    repeat (2) @(posedge clk);
    #1;
    check({sdo, 3'h0, oversample_ratio}, 32'h11F);
    // Continuous conversion, chip select held low.
    res  <= 31'($urandom());
    do_reset(1'b1, 1'b1);
    repeat (30) @(posedge clk);
    #1;
    check({sck_o, sdo, busy}, 32'h7);
    wait_busy(1'b0);
    check({sck_o, sdo}, 32'h0);
    exp_q.push_back({1'b0, res});
    wait_sck();
    check(32'(n >= 19 && n <= 24), 32'h1);
    wait_busy(1'b1);
    repeat (40) @(posedge clk);
    #1;
    check({sck_o, sdo, busy}, 32'h7);
    repeat (5) @(posedge clk);
    check(exp_q.size(), 32'h0);
    results();
  end
endmodule // testbench

`default_nettype wire
